// ### src/smc_standby_ctrl.v
// standby mode sequencer: halt and stop entry, wake decision, waits
// assumes cpu strobes and interrupt flags are synchronous to pclk
//
// Functional notes
// R1: reset during halt leaves halt and runs the normal reset sequence.
// R2: mask holds standby; else enable and priority pick service or next.
// R3: stop instruction enters stop from either cpu clock source.
// R4: pending unmasked request at stop drops to halt, resumes after wait; the code goes to the ST_STAB stabilization wait instead of halt.
// R5: stop halts high-speed oscillator and gates cpu clock.
// R6: port output latches hold their value throughout stop.
// R7: timer 50 counts in stop only on its external input.
// R8: serial port runs in stop only from running timer 51 output.
// R9: watchdog stops in stop only if oscillator stoppable and stopped.
// R10: software switches to low-speed clock before issuing stop.
// R11: interrupt in stop waits stabilization, then services or continues.
// R12: software waits about 350 us before switching main clock.
// R13: external clock input skips the stabilization wait.
// R14: halt release waits 8 clocks to service, 2 to continue.
// R15: reset in stop runs reset sequence after stabilization time.
// R16: listed peripherals stop in stop; always-on blocks keep running.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "smc_defs.vh"

module smc_standby_ctrl
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        halt_exec,
    input  wire        stop_exec,
    input  wire        reset_req,
    input  wire        int_request,
    input  wire        interrupt_mask_flag,
    input  wire        interrupt_priority_flag,
    input  wire        global_interrupt_enable,
    input  wire        in_service_priority_flag,
    output reg         cpu_clk_en,
    output reg         hs_osc_en,
    output reg         port_latch_hold,
    output reg         timer50_run,
    output reg         serial_port_zero_run,
    output reg         watchdog_run,
    output reg         periph_run,
    output reg         always_on_run,
    output reg         vector_req,
    output reg         next_instr,
    output reg         reset_seq,
    output reg         main_clock_select_bit,
    output reg  [5:0]  standby_state
);

localparam [5:0] ST_RUN  = 6'h01;
localparam [5:0] ST_HALT = 6'h02;
localparam [5:0] ST_STOP = 6'h04;
localparam [5:0] ST_STAB = 6'h08;
localparam [5:0] ST_WAIT = 6'h10;
localparam [5:0] ST_RSTQ = 6'h20;

reg  [`SMC_CTRL_W-1:0] ctrl;
reg  [5:0]             state;
reg  [5:0]             next_state;
reg  [3:0]             wait_cnt;
reg  [3:0]             next_wait_cnt;
reg                    serve;
reg                    next_serve;
reg                    pend_rst;
reg                    next_pend_rst;
reg                    stab_start;
reg                    next_stab_start;
reg                    next_vector;
reg                    next_next;
reg                    next_reset;
reg  [31:0]            next_prdata;
reg                    next_err;

wire                   stab_done;
wire [`SMC_CNT_W-1:0]  osc_stab_status_counter;
wire [2:0]             osc_stab_time_select;
wire                   wake;
wire                   decide_serve;
wire                   in_stop;
wire                   apb_setup;
wire                   apb_wr;

assign osc_stab_time_select = ctrl[`SMC_CTRL_OSC_STAB_TIME_SELECT_HI:`SMC_CTRL_OSC_STAB_TIME_SELECT_LO];

////////////////////////////////////////////////////////////////////////
// wake decision

// a set mask keeps the block in standby
assign wake = int_request && !interrupt_mask_flag;                   // R2
// low priority source needs the in-service flag as well
assign decide_serve = global_interrupt_enable &&
                      (!interrupt_priority_flag || in_service_priority_flag); // R2

////////////////////////////////////////////////////////////////////////
// apb slave, one wait state so every output leaves a flop

assign apb_setup = psel && !penable;
assign apb_wr    = psel && penable && pwrite && !pready;

always @*
begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    case (paddr)
        `SMC_OFS_CTRL:
        begin
            next_prdata[`SMC_CTRL_W-1:0] = ctrl;
        end
        `SMC_OFS_STATUS:
        begin
            next_prdata[`SMC_STAT_STATE_HI:`SMC_STAT_STATE_LO] = state;
            next_prdata[`SMC_STAT_CNT_HI:`SMC_STAT_CNT_LO] = osc_stab_status_counter;
        end
        `SMC_OFS_CLKMODE:
        begin
            next_prdata[0] = main_clock_select_bit;
        end
        default:
        begin
            next_err = 1'b1;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end
    else
    begin
        pready  <= psel && penable && !pready;
        pslverr <= psel && penable && !pready && next_err;
        if (psel && penable && !pready && !pwrite)
        begin
            prdata <= next_prdata;
        end
        else if (apb_setup)
        begin
            prdata <= 32'h0000_0000;
        end
    end
end

// registers; write lands one edge before pready is seen high
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl                  <= `SMC_CTRL_RST;
        main_clock_select_bit <= `SMC_CLKMODE_RST;
    end
    else if (apb_wr)
    begin
        if (paddr == `SMC_OFS_CTRL)
        begin
            ctrl <= pwdata[`SMC_CTRL_W-1:0];
        end
        // stabilization delay before switching is left to software
        if (paddr == `SMC_OFS_CLKMODE)
        begin
            main_clock_select_bit <= pwdata[0];                         // R12
        end
    end
end

////////////////////////////////////////////////////////////////////////
// stabilization counter

smc_stab_timer u_stab
(
    .pclk    (pclk),
    .presetn (presetn),
    .start   (stab_start),
    .sel     (osc_stab_time_select),
    .bypass  (ctrl[`SMC_CTRL_EXTCLK]),                                   // R13
    .done    (stab_done),
    .count   (osc_stab_status_counter)
);

////////////////////////////////////////////////////////////////////////
// sequencer

always @*
begin
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_serve      = serve;
    next_pend_rst   = pend_rst;
    next_stab_start = 1'b0;
    next_vector     = 1'b0;
    next_next       = 1'b0;
    next_reset      = 1'b0;
    case (state)
        ST_RUN:
        begin
            if (reset_req)
            begin
                next_state = ST_RSTQ;
            end
            else if (halt_exec)
            begin
                next_state = ST_HALT;
            end
            // stop is refused while the internal fast oscillator runs
            else if (stop_exec && !ctrl[`SMC_CTRL_HSI_ON])              // R10
            begin
                if (wake)
                begin
                    next_state      = ST_STAB;                        // R4
                    next_serve      = decide_serve;
                    next_stab_start = 1'b1;
                end
                else
                begin
                    next_state = ST_STOP;                             // R3
                end
            end
        end
        ST_HALT:
        begin
            if (reset_req)
            begin
                next_state = ST_RSTQ;                                 // R1
            end
            else if (wake)
            begin
                next_state    = ST_WAIT;
                next_serve    = decide_serve;
                next_wait_cnt = decide_serve ? `SMC_WAIT_VECT :
                                `SMC_WAIT_NEXT;                       // R14
            end
        end
        ST_STOP:
        begin
            if (reset_req)
            begin
                next_state      = ST_STAB;                            // R15
                next_pend_rst   = 1'b1;
                next_stab_start = 1'b1;
            end
            else if (wake)
            begin
                next_state      = ST_STAB;                            // R11
                next_serve      = decide_serve;
                next_stab_start = 1'b1;
            end
        end
        ST_STAB:
        begin
            if (reset_req)
            begin
                next_pend_rst = 1'b1;
            end
            if (stab_done)
            begin
                if (pend_rst || reset_req)
                begin
                    next_state = ST_RSTQ;                             // R15
                end
                else
                begin
                    next_state  = ST_RUN;                             // R11
                    next_vector = serve;
                    next_next   = !serve;
                end
            end
        end
        ST_WAIT:
        begin
            if (reset_req)
            begin
                next_state = ST_RSTQ;
            end
            else if (wait_cnt == 4'd1)
            begin
                next_state  = ST_RUN;                                 // R14
                next_vector = serve;
                next_next   = !serve;
            end
            else
            begin
                next_wait_cnt = wait_cnt - 4'd1;
            end
        end
        ST_RSTQ:
        begin
            // cpu restarts from the reset vector on this pulse
            next_state    = ST_RUN;                                   // R1
            next_reset    = 1'b1;
            next_pend_rst = 1'b0;
        end
        default:
        begin
            next_state = ST_RUN;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state      <= ST_RUN;
        wait_cnt   <= 4'h0;
        serve      <= 1'b0;
        pend_rst   <= 1'b0;
        stab_start <= 1'b0;
        vector_req <= 1'b0;
        next_instr <= 1'b0;
        reset_seq  <= 1'b0;
    end
    else
    begin
        state      <= next_state;
        wait_cnt   <= next_wait_cnt;
        serve      <= next_serve;
        pend_rst   <= next_pend_rst;
        stab_start <= next_stab_start;
        vector_req <= next_vector;
        next_instr <= next_next;
        reset_seq  <= next_reset;
    end
end

////////////////////////////////////////////////////////////////////////
// clock and peripheral gating, registered from the next state

// stabilization still counts as stop: oscillator starting, cpu gated
assign in_stop = next_state == ST_STOP || next_state == ST_STAB;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cpu_clk_en           <= 1'b1;
        hs_osc_en            <= 1'b1;
        port_latch_hold      <= 1'b0;
        timer50_run          <= 1'b1;
        serial_port_zero_run <= 1'b1;
        watchdog_run         <= 1'b1;
        periph_run           <= 1'b1;
        always_on_run        <= 1'b1;
        standby_state        <= ST_RUN;
    end
    else
    begin
        // halt keeps the oscillator, only the cpu clock stops
        cpu_clk_en      <= !in_stop && next_state != ST_HALT &&
                           next_state != ST_WAIT;                     // R5
        hs_osc_en       <= next_state != ST_STOP;                     // R5
        port_latch_hold <= in_stop;                                   // R6
        timer50_run     <= !in_stop || ctrl[`SMC_CTRL_T50_EXT];       // R7
        serial_port_zero_run <= !in_stop ||
                                (ctrl[`SMC_CTRL_UART_T51] &&
                                 ctrl[`SMC_CTRL_T51_RUN]);            // R8
        watchdog_run    <= !in_stop || !(ctrl[`SMC_CTRL_LSO_OPT] &&
                                         ctrl[`SMC_CTRL_LSO_STOP]);   // R9
        periph_run      <= !in_stop;                                  // R16
        always_on_run   <= 1'b1;                                      // R16
        standby_state   <= next_state;
    end
end

endmodule // smc_standby_ctrl

// ### src/smc_defs.vh
// constants for the standby mode controller: register map, field
// positions, reset values and timing counts; included by bare name
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// register byte offsets on the apb bus
`define SMC_OFS_CTRL       12'h000
`define SMC_OFS_STATUS     12'h004
`define SMC_OFS_CLKMODE    12'h008
`define SMC_ADDR_W         12

// control register fields
`define SMC_CTRL_OSC_STAB_TIME_SELECT_LO   0
`define SMC_CTRL_OSC_STAB_TIME_SELECT_HI   2
`define SMC_CTRL_EXTCLK    3
`define SMC_CTRL_LSO_OPT   4
`define SMC_CTRL_LSO_STOP  5
`define SMC_CTRL_T50_EXT   6
`define SMC_CTRL_UART_T51  7
`define SMC_CTRL_T51_RUN   8
`define SMC_CTRL_HSI_ON    9
`define SMC_CTRL_W         10
`define SMC_CTRL_RST       10'h000

// status register fields
`define SMC_STAT_STATE_LO  0
`define SMC_STAT_STATE_HI  5
`define SMC_STAT_CNT_LO    8
`define SMC_STAT_CNT_HI    23

// clock mode register reset value
`define SMC_CLKMODE_RST    1'b0

// stabilization: tick every STAB_DIV pclk, length 2^(sel+STAB_BASE) ticks
`define SMC_STAB_DIV       8'd25
`define SMC_STAB_BASE      4'd4
`define SMC_CNT_W          16

// wake waits in cpu clocks after interrupt release
`define SMC_WAIT_VECT      4'd8
`define SMC_WAIT_NEXT      4'd2

`endif

// ### src/smc_stab_timer.v
// oscillation stabilization counter with its own tick divider
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ns
`include "smc_defs.vh"

module smc_stab_timer
(
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  start,
    input  wire [2:0]            sel,
    input  wire                  bypass,
    output reg                   done,
    output reg  [`SMC_CNT_W-1:0] count
);

reg  [7:0]             div;
reg                    tick;
reg                    busy;
reg  [`SMC_CNT_W-1:0]  limit;
wire [3:0]             shift;

assign shift = {1'b0, sel} + `SMC_STAB_BASE;

////////////////////////////////////////////////////////////////////////
// divider: one-cycle tick, restarted with each wait
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        div  <= 8'h00;
        tick <= 1'b0;
    end
    else if (start || div == `SMC_STAB_DIV - 8'd1)
    begin
        div  <= 8'h00;
        tick <= !start;
    end
    else
    begin
        div  <= div + 8'd1;
        tick <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// external clock needs no wait, so bypass finishes next cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        busy  <= 1'b0;
        done  <= 1'b0;
        count <= {`SMC_CNT_W{1'b0}};
        limit <= {`SMC_CNT_W{1'b0}};
    end
    else if (start)
    begin
        busy  <= !bypass;
        done  <= bypass;
        count <= {`SMC_CNT_W{1'b0}};
        limit <= {{(`SMC_CNT_W-1){1'b0}}, 1'b1} << shift;
    end
    else if (busy && tick)
    begin
        count <= count + {{(`SMC_CNT_W-1){1'b0}}, 1'b1};
        if (count + {{(`SMC_CNT_W-1){1'b0}}, 1'b1} == limit)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
        end
    end
    else
    begin
        done <= 1'b0;
    end
end

endmodule // smc_stab_timer

// ### test/smc_props.sv
// assertions on the standby controller ports
// bound to smc_standby_ctrl, single pclk domain
`timescale 1ns/1ns
module smc_props
(
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    input wire       stop_exec,
    input wire       reset_req,
    input wire       int_request,
    input wire       interrupt_mask_flag,
    input wire       interrupt_priority_flag,
    input wire       global_interrupt_enable,
    input wire       in_service_priority_flag,
    input wire       cpu_clk_en,
    input wire       hs_osc_en,
    input wire       port_latch_hold,
    input wire       periph_run,
    input wire       always_on_run,
    input wire       vector_req,
    input wire       next_instr,
    input wire       reset_seq,
    input wire [5:0] standby_state
);
default clocking dc @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////
wire serve = global_interrupt_enable
           & (~interrupt_priority_flag | in_service_priority_flag);
wire wake  = int_request & ~interrupt_mask_flag & ~reset_req;
sequence s_halt_wake;
    standby_state == 6'h02 && wake;
endsequence
sequence s_wait_vect;
    (standby_state == 6'h10)[*8] ##1 (vector_req && standby_state == 6'h01);
endsequence
sequence s_wait_next;
    (standby_state == 6'h10)[*2] ##1 (next_instr && standby_state == 6'h01);
endsequence
a_wake_vect_wait: assert property (s_halt_wake ##0 serve |=> s_wait_vect)
    else $error("halt service wait wrong");
a_wake_next_wait: assert property (s_halt_wake ##0 !serve |=> s_wait_next)
    else $error("halt continue wait wrong");
a_mask_holds: assert property (standby_state == 6'h02 && int_request
    && interrupt_mask_flag && !reset_req |=> standby_state == 6'h02)
    else $error("masked wake left halt");
a_halt_reset: assert property (standby_state == 6'h02 && reset_req
    |=> standby_state == 6'h20 ##1 (reset_seq && standby_state == 6'h01))
    else $error("reset in halt wrong");
a_stop_entry: assert property ($rose(standby_state == 6'h04) |-> $past(stop_exec))
    else $error("stop without strobe");
a_stop_gates: assert property (standby_state == 6'h04 |-> !hs_osc_en && !cpu_clk_en)
    else $error("clocks run in stop");
a_port_hold: assert property (standby_state == 6'h04 |-> port_latch_hold)
    else $error("port latch not held");
a_periph_off: assert property (standby_state == 6'h04 |-> !periph_run && always_on_run)
    else $error("peripheral gating wrong");
a_stop_wake: assert property (standby_state == 6'h04 && wake |=> standby_state == 6'h08)
    else $error("stop wake not stabilizing");
a_apb_ready: assert property (psel && penable && !pready |=> pready && $stable(psel))
    else $error("apb answer late");
a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // smc_props
bind smc_standby_ctrl smc_props u_props (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .stop_exec, .reset_req, .int_request, .interrupt_mask_flag,
    .interrupt_priority_flag, .global_interrupt_enable, .in_service_priority_flag,
    .cpu_clk_en, .hs_osc_en, .port_latch_hold, .periph_run, .always_on_run,
    .vector_req, .next_instr, .reset_seq, .standby_state);

// ### test/smc_cpu_model.sv
// cpu core and interrupt source side of the standby controller
// tasks are called right after a rising pclk edge
`timescale 1ns/1ns
module smc_cpu_model
(
    input  wire pclk,
    output reg  halt_exec,
    output reg  stop_exec,
    output reg  reset_req,
    output reg  int_request,
    output reg  interrupt_mask_flag,
    output reg  interrupt_priority_flag,
    output reg  global_interrupt_enable,
    output reg  in_service_priority_flag
);
initial {halt_exec, stop_exec, reset_req, int_request} = 4'h0;
initial {interrupt_mask_flag, interrupt_priority_flag} = 2'h0;
initial {global_interrupt_enable, in_service_priority_flag} = 2'h0;
// one strobe per run period, each ends on an edge
task strobe(input is_stop);
    halt_exec <= !is_stop;
    stop_exec <= is_stop;
    @(posedge pclk);
    {halt_exec, stop_exec} <= 2'h0;
    @(posedge pclk);
endtask
task flags(input [3:0] f);
    {interrupt_mask_flag, interrupt_priority_flag} <= f[3:2];
    {global_interrupt_enable, in_service_priority_flag} <= f[1:0];
    @(posedge pclk);
endtask
task wake(input v);
    int_request <= v;
    @(posedge pclk);
endtask
task rst(input v);
    reset_req <= v;
    @(posedge pclk);
endtask
endmodule // smc_cpu_model

// ### test/smc_standby_ctrl_tb_top.sv
// self-checking bench for the standby controller
// apb master, cpu model, queued expectations
`timescale 1ns/1ns
`include "smc_defs.vh"
module smc_standby_ctrl_tb_top;
reg         pclk;
reg         presetn;
reg         psel;
reg         penable;
reg         pwrite;
reg  [11:0] paddr;
reg  [31:0] pwdata;
wire [31:0] prdata;
wire        pready, pslverr, halt_exec, stop_exec, reset_req, int_request;
wire        mask_f, prio_f, ie_f, isp_f, cpu_clk_en, hs_osc_en, port_latch_hold;
wire        timer50_run, serial_port_zero_run, watchdog_run, periph_run, always_on_run;
wire        vector_req, next_instr, reset_seq, main_clock_select_bit;
wire [5:0]  standby_state;
integer     errors, n_checks, cyc, i, n;
reg  [31:0] lfsr, r;
reg  [9:0]  c;
reg  [33:0] exp_rd[$];
reg  [2:0]  exp_ev[$];
reg  [33:0] me;
smc_standby_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_exec(halt_exec), .stop_exec(stop_exec),
    .reset_req(reset_req), .int_request(int_request), .interrupt_mask_flag(mask_f),
    .interrupt_priority_flag(prio_f), .global_interrupt_enable(ie_f),
    .in_service_priority_flag(isp_f), .cpu_clk_en(cpu_clk_en), .hs_osc_en(hs_osc_en),
    .port_latch_hold(port_latch_hold), .timer50_run(timer50_run),
    .serial_port_zero_run(serial_port_zero_run), .watchdog_run(watchdog_run),
    .periph_run(periph_run), .always_on_run(always_on_run), .vector_req(vector_req),
    .next_instr(next_instr), .reset_seq(reset_seq),
    .main_clock_select_bit(main_clock_select_bit), .standby_state(standby_state));
smc_cpu_model u_cpu (.pclk(pclk), .halt_exec(halt_exec), .stop_exec(stop_exec),
    .reset_req(reset_req), .int_request(int_request), .interrupt_mask_flag(mask_f),
    .interrupt_priority_flag(prio_f), .global_interrupt_enable(ie_f),
    .in_service_priority_flag(isp_f));
////////////////////////////////////////////////////////////////
initial
begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end
function [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
endfunction
task chk(input [8*10-1:0] nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
        errors = errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
    end
endtask
task summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
// e: {compare data, expected error, expected data}; an idle cycle follows
task apb(input w, input [11:0] a, input [31:0] d, input [33:0] e);
    exp_rd.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the cycle ceiling ends a stuck access
    while (pready !== 1'b1)
    begin
        @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task wait_run(output integer m);
    m = 0;
    while (standby_state !== 6'h01 && m < 3000)
    begin
        @(posedge pclk);
        m = m + 1;
    end
    @(posedge pclk);
endtask
////////////////////////////////////////////////////////////////
// monitor: oldest note against each answer or release pulse
always @(posedge pclk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        errors = errors + 1;
        summarize;
    end
    if (presetn && pready === 1'b1)
    begin
        me = exp_rd.size() ? exp_rd.pop_front() : 34'h2_ffff_ffff;
        chk("pslverr", me[32], pslverr);
        if (me[33])
            chk("prdata", me[31:0], prdata);
    end
    if ({reset_seq, next_instr, vector_req} !== 3'h0)
        chk("event", exp_ev.size() ? exp_ev.pop_front() : 3'h0,
            {reset_seq, next_instr, vector_req});
end
initial
begin
    {errors, n_checks, cyc} = 0;
    lfsr = 32'hc94626a3;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `SMC_OFS_CTRL, rnd(), {2'b10, 22'h0, `SMC_CTRL_RST});
    apb(0, `SMC_OFS_STATUS, rnd(), {2'b10, 32'h1});
    apb(0, `SMC_OFS_CLKMODE, rnd(), {2'b10, 32'h0});
    apb(1, 12'h00c, rnd(), {2'b01, 32'h0});
    apb(0, 12'h00c, rnd(), {2'b11, 32'h0});
    r = rnd();
    apb(1, `SMC_OFS_CTRL, r, 34'h0);
    apb(0, `SMC_OFS_CTRL, rnd(), {2'b10, 22'h0, r[9:0]});
    repeat (85) @(posedge pclk);
    r = rnd();
    apb(1, `SMC_OFS_CLKMODE, {r[31:1], 1'b1}, 34'h0);
    chk("clk_sel", 1, main_clock_select_bit);
    $display("done registers");
    for (i = 0; i < 8; i = i + 1)
    begin
        r = rnd();
        u_cpu.flags({r[0], i[2:0]});
        u_cpu.strobe(0);
        chk("halt", 6'h02, standby_state);
        chk("halt_clk", 32'h2, {hs_osc_en, cpu_clk_en});
        exp_ev.push_back((i[1] & (!i[2] | i[0])) ? 3'h1 : 3'h2);
        u_cpu.wake(1);
        if (r[0])
        begin
            repeat (12) @(posedge pclk);
            chk("held", 6'h02, standby_state);
            u_cpu.flags({1'b0, i[2:0]});
        end
        wait_run(n);
        u_cpu.wake(0);
    end
    $display("done halt table");
    for (i = 0; i < 4; i = i + 1)
    begin
        r = rnd();
        c = {1'b0, r[8:4], 4'h8};
        apb(1, `SMC_OFS_CTRL, {22'h0, c}, 34'h0);
        u_cpu.strobe(1);
        chk("stop", 6'h04, standby_state);
        chk("stop_out", {4'h0, c[6], c[7] & c[8], !(c[4] & c[5]), 2'h3},
            {hs_osc_en, cpu_clk_en, !port_latch_hold, periph_run, timer50_run,
            serial_port_zero_run, watchdog_run, always_on_run, 1'b1});
        // priority 0, so enable alone picks service; in-service bit is free
        u_cpu.flags({2'h0, i[0], r[9]});
        exp_ev.push_back(i[0] ? 3'h1 : 3'h2);
        u_cpu.wake(1);
        wait_run(n);
        chk("ext_fast", 1, n < 20);
        u_cpu.wake(0);
    end
    u_cpu.flags({3'h1, r[0]});
    u_cpu.wake(1);
    exp_ev.push_back(3'h1);
    u_cpu.strobe(1);
    wait_run(n);
    u_cpu.wake(0);
    r = rnd();
    apb(1, `SMC_OFS_CTRL, {r[31:10], 1'b1, r[8:0]}, 34'h0);
    u_cpu.strobe(1);
    chk("refused", 6'h01, standby_state);
    $display("done stop");
    // shortest wait and no bypass, so the stabilization length shows
    apb(1, `SMC_OFS_CTRL, {r[31:10], 1'b0, r[8:4], 4'h0}, 34'h0);
    u_cpu.strobe(1);
    exp_ev.push_back(3'h4);
    // request is latched in stab; a held level would reset again in run
    u_cpu.rst(1);
    u_cpu.rst(0);
    wait_run(n);
    chk("stab_len", 1, n > 300);
    u_cpu.strobe(0);
    exp_ev.push_back(3'h4);
    u_cpu.rst(1);
    u_cpu.rst(0);
    wait_run(n);
    repeat (4) @(posedge pclk);
    chk("pending", 0, exp_ev.size() + exp_rd.size());
    $display("done resets");
    summarize;
end
endmodule // smc_standby_ctrl_tb_top
